// ### rtl/fsl_flash_mem.sv
// Flash array model: one program/erase port and two registered read ports.
`include "fsl_params.svh"

module fsl_flash_mem (
    // Clock.
    input wire logic clock,
    // Program and erase port.
    input wire logic wr_en,
    input wire logic erase_en,
    input wire logic [`FSL_FA_W-1:0] waddr,
    input wire logic [`FSL_FD_W-1:0] wdata,
    // Read port for software and boot.
    input wire logic [`FSL_FA_W-1:0] raddr_a,
    output logic [`FSL_FD_W-1:0] rdata_a,
    // Read port for the debug path.
    input wire logic [`FSL_FA_W-1:0] raddr_b,
    output logic [`FSL_FD_W-1:0] rdata_b
);
    // Storage keeps its contents through every reset.
    logic [`FSL_FD_W-1:0] mem [0:`FSL_FLASH_WORDS-1];

    // The array leaves the factory erased.
    initial begin
        for (int i = 0; i < `FSL_FLASH_WORDS; i++) begin
            mem[i] = `FSL_ERASED;
        end
    end

    // Programming can only pull bits low; only an erase sets them back to one.
    always_ff @(posedge clock) begin
        if (wr_en) begin
            mem[waddr] <= erase_en ? `FSL_ERASED : (mem[waddr] & wdata);
        end
        rdata_a <= mem[raddr_a];
        rdata_b <= mem[raddr_b];
    end
endmodule // fsl_flash_mem

// ### rtl/fsl_lockout.sv
// Flash security interlock: TAP controller, lockout recovery erase and software port.
//
// Local design decisions: the strobed register port and the register addresses.
`include "fsl_params.svh"

module fsl_lockout #(
    parameter logic [31:0] ID_CODE = 32'h1000_0001 // Arbitrary identification value.
) (
    // Clock and resets.
    input wire logic clock,
    input wire logic rst,
    input wire logic por,
    // Test access pins, sampled on the system clock.
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe,
    // Software register port.
    input wire fsl_pkg::fsl_bus_req_t bus_req,
    output logic [31:0] rdata,
    // Security state to the rest of the chip.
    output logic secured,
    output logic core_debug_en,
    output logic erase_busy
);
    import fsl_pkg::*;
    ////////////////////////////////////////////////////////////////////////////////
    // Functions.
    // TAP next state for a mode-select value.
    function automatic fsl_tap_state_t tap_next(input fsl_tap_state_t s, input logic m);
        case (s)
            FSL_TLR: tap_next = m ? FSL_TLR : FSL_RTI;
            FSL_RTI: tap_next = m ? FSL_SEL_DR : FSL_RTI;
            FSL_SEL_DR: tap_next = m ? FSL_SEL_IR : FSL_CAP_DR;
            FSL_CAP_DR: tap_next = m ? FSL_EX1_DR : FSL_SH_DR;
            FSL_SH_DR: tap_next = m ? FSL_EX1_DR : FSL_SH_DR;
            FSL_EX1_DR: tap_next = m ? FSL_UPD_DR : FSL_PAU_DR;
            FSL_PAU_DR: tap_next = m ? FSL_EX2_DR : FSL_PAU_DR;
            FSL_EX2_DR: tap_next = m ? FSL_UPD_DR : FSL_SH_DR;
            FSL_UPD_DR: tap_next = m ? FSL_SEL_DR : FSL_RTI;
            FSL_SEL_IR: tap_next = m ? FSL_TLR : FSL_CAP_IR;
            FSL_CAP_IR: tap_next = m ? FSL_EX1_IR : FSL_SH_IR;
            FSL_SH_IR: tap_next = m ? FSL_EX1_IR : FSL_SH_IR;
            FSL_EX1_IR: tap_next = m ? FSL_UPD_IR : FSL_PAU_IR;
            FSL_PAU_IR: tap_next = m ? FSL_EX2_IR : FSL_PAU_IR;
            FSL_EX2_IR: tap_next = m ? FSL_UPD_IR : FSL_SH_IR;
            FSL_UPD_IR: tap_next = m ? FSL_SEL_DR : FSL_RTI;
            default: tap_next = FSL_TLR;
        endcase
    endfunction

    // Data register length selected by the instruction.
    function automatic logic [5:0] dr_len(input logic [`FSL_IR_W-1:0] ir);
        case (ir)
            `FSL_IR_IDCODE: dr_len = `FSL_LEN_ID;
            `FSL_IR_LOCKOUT: dr_len = `FSL_LEN_DIV;
            `FSL_IR_DBG_ADDR: dr_len = `FSL_LEN_ADDR;
            `FSL_IR_DBG_READ: dr_len = `FSL_LEN_DATA;
            default: dr_len = `FSL_LEN_BYPASS;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // State.
    fsl_tap_state_t tap_reg; // TAP controller state.
    logic tck_q_reg; // Test clock one cycle ago, for edge detection.
    logic [`FSL_IR_W-1:0] ir_reg; // Active instruction.
    logic [`FSL_IR_W-1:0] ir_sh_reg; // Instruction shifter.
    logic [`FSL_DR_W-1:0] dr_reg; // Data shifter shared by all data registers.
    logic [`FSL_DIV_W-1:0] div_reg; // Divider last loaded by the host.
    logic div_valid_reg; // A divider has been loaded under the recovery instruction.
    logic [`FSL_DIV_W-1:0] erase_div_reg; // Divider frozen for the running erase.
    logic [`FSL_DIV_W-1:0] erase_cnt_reg; // Cycles since the last erase step.
    logic [`FSL_FA_W-1:0] erase_addr_reg; // Next word to erase.
    logic done_reg; // Full erase finished since the last device reset.
    logic aborted_reg; // The latest erase was cut short; cleared by a device reset or a new erase start.
    logic boot_pending_reg; // First cycle after reset, security word being fetched.
    logic [`FSL_FA_W-1:0] faddr_reg; // Software flash address.
    logic [`FSL_FA_W-1:0] dbg_addr_reg; // Debug flash address.
    logic [`FSL_FD_W-1:0] q_a; // Flash word for software and boot.
    logic [`FSL_FD_W-1:0] q_b; // Flash word for the debug path.

    ////////////////////////////////////////////////////////////////////////////////
    // Decoding.
    wire tck_rise = tck & ~tck_q_reg;
    wire fsl_tap_state_t tap_next_s = tap_next(tap_reg, tms);
    wire adv = tck_rise;
    wire [5:0] len = dr_len(ir_reg);
    wire is_lockout = (ir_reg == `FSL_IR_LOCKOUT);
    wire rti_entry = adv && (tap_next_s == FSL_RTI) && (tap_reg != FSL_RTI);
    // Erase begins on entering idle with the recovery instruction and a loaded divider.
    wire erase_start = rti_entry && is_lockout && div_valid_reg && !erase_busy;
    wire erase_tick = erase_busy && (erase_cnt_reg == erase_div_reg);
    wire erase_last = erase_tick && (erase_addr_reg == `FSL_ADDR_LAST);
    // Leaving idle, or a TAP reset, ends the erase early.
    wire erase_abort = erase_busy && ((tap_reg != FSL_RTI) || por) && !erase_last;
    wire bus_prog = bus_req.wr && (bus_req.addr == `FSL_OFF_FDATA) && !erase_busy;
    wire mem_wr = erase_tick || bus_prog;
    wire [`FSL_FA_W-1:0] mem_waddr = erase_busy ? erase_addr_reg : faddr_reg;
    wire [`FSL_FA_W-1:0] mem_raddr_a = boot_pending_reg ? `FSL_SEC_ADDR : faddr_reg;
    wire [`FSL_DR_W-1:0] dr_shifted = (dr_reg >> 1) | ({{(`FSL_DR_W-1){1'b0}}, tdi} << (len - 6'h01));
    // Debug reads of flash yield zero while secured.
    wire [`FSL_FD_W-1:0] dbg_word = secured ? `FSL_FD_W'(0) : q_b;
    wire shifting = (tap_reg == FSL_SH_DR) || (tap_reg == FSL_SH_IR);
    wire fsl_status_t status = '{aborted: aborted_reg, done: done_reg, busy: erase_busy,
                                 dbg_en: core_debug_en, secured: secured};

    ////////////////////////////////////////////////////////////////////////////////
    // Flash array.
    fsl_flash_mem u_mem (
        .clock(clock),
        .wr_en(mem_wr),
        .erase_en(erase_busy),
        .waddr(mem_waddr),
        .wdata(bus_req.wdata[`FSL_FD_W-1:0]),
        .raddr_a(mem_raddr_a),
        .rdata_a(q_a),
        .raddr_b(dbg_addr_reg),
        .rdata_b(q_b)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // TAP controller, reset by power-on reset and by five mode-select highs.
    // The state walks on each test-clock rising edge.
    always_ff @(posedge clock) begin
        tck_q_reg <= por ? 1'b0 : tck;
        if (por) begin
            tap_reg <= FSL_TLR;
        end else if (adv) begin
            tap_reg <= tap_next_s;
        end
    end

    // Instruction register; identification is the default after reset.
    always_ff @(posedge clock) begin
        if (por || (tap_reg == FSL_TLR)) begin
            ir_reg <= `FSL_IR_IDCODE;
            ir_sh_reg <= `FSL_IR_CAPTURE;
        end else if (adv) begin
            case (tap_reg)
                FSL_CAP_IR: ir_sh_reg <= `FSL_IR_CAPTURE;
                FSL_SH_IR: ir_sh_reg <= {tdi, ir_sh_reg[`FSL_IR_W-1:1]};
                FSL_UPD_IR: ir_reg <= ir_sh_reg;
                default: ir_sh_reg <= ir_sh_reg;
            endcase
        end
    end

    // Data shifter: capture and shift for each instruction.
    always_ff @(posedge clock) begin
        if (por) begin
            dr_reg <= '0;
        end else if (adv && tap_reg == FSL_CAP_DR) begin
            case (ir_reg)
                `FSL_IR_IDCODE: dr_reg <= ID_CODE;
                `FSL_IR_DBG_READ: dr_reg <= {{(`FSL_DR_W-`FSL_FD_W){1'b0}}, dbg_word};
                `FSL_IR_LOCKOUT: dr_reg <= {{(`FSL_DR_W-`FSL_DIV_W){1'b0}}, div_reg};
                default: dr_reg <= '0;
            endcase
        end else if (adv && tap_reg == FSL_SH_DR) begin
            dr_reg <= dr_shifted;
        end
    end

    // Update stage, loaded in every Update-DR cycle so the divider stands before idle entry starts an erase.
    always_ff @(posedge clock) begin
        if (por) begin
            div_reg <= '0;
            div_valid_reg <= 1'b0;
            dbg_addr_reg <= `FSL_ADDR_FIRST;
        end else if (tap_reg == FSL_UPD_DR) begin
            if (is_lockout) begin
                div_reg <= dr_reg[`FSL_DIV_W-1:0];
                div_valid_reg <= 1'b1;
            end else if (ir_reg == `FSL_IR_DBG_ADDR && !secured) begin
                dbg_addr_reg <= dr_reg[`FSL_FA_W-1:0];
            end
        end
    end

    // Serial output follows the shifter low bit, enabled only while shifting.
    always_ff @(posedge clock) begin
        if (por) begin
            tdo <= 1'b0;
            tdo_oe <= 1'b0;
        end else begin
            tdo <= (tap_reg == FSL_SH_IR) ? ir_sh_reg[0] : dr_reg[0];
            tdo_oe <= shifting;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Mass erase sequencer.
    // Steps one word every divider period while the host waits in idle.
    always_ff @(posedge clock) begin
        if (rst) begin
            erase_busy <= 1'b0;
            erase_cnt_reg <= '0;
            erase_addr_reg <= `FSL_ADDR_FIRST;
            erase_div_reg <= '0;
        end else if (erase_start) begin
            erase_busy <= 1'b1;
            erase_cnt_reg <= '0;
            erase_addr_reg <= `FSL_ADDR_FIRST;
            erase_div_reg <= div_reg;
        end else if (erase_last || erase_abort) begin
            erase_busy <= 1'b0;
        end else if (erase_tick) begin
            erase_cnt_reg <= '0;
            erase_addr_reg <= erase_addr_reg + `FSL_FA_W'(1);
        end else if (erase_busy) begin
            erase_cnt_reg <= erase_cnt_reg + `FSL_DIV_W'(1);
        end
    end

    // Done flag lasts until the next device reset; the abort flag also clears when an erase starts.
    always_ff @(posedge clock) begin
        if (rst) begin
            done_reg <= 1'b0;
            aborted_reg <= 1'b0;
        end else begin
            done_reg <= done_reg | erase_last;
            aborted_reg <= (aborted_reg & ~erase_start) | erase_abort;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Security state, decided once per device reset from the stored word.
    // Secured by default in reset; the word read at release decides.
    always_ff @(posedge clock) begin
        if (rst) begin
            boot_pending_reg <= 1'b1;
            secured <= 1'b1;
            core_debug_en <= 1'b0;
        end else begin
            boot_pending_reg <= 1'b0;
            if (boot_pending_reg) begin
                secured <= (q_a == `FSL_SEC_VAL);
            end
            core_debug_en <= !secured;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Software register port.
    // Address register and read data; reads answer in the next cycle.
    always_ff @(posedge clock) begin
        if (rst) begin
            faddr_reg <= `FSL_ADDR_FIRST;
            rdata <= '0;
        end else begin
            if (bus_req.wr && bus_req.addr == `FSL_OFF_FADDR) begin
                faddr_reg <= bus_req.wdata[`FSL_FA_W-1:0];
            end
            if (bus_req.rd) begin
                case (bus_req.addr)
                    `FSL_OFF_STATUS: rdata <= {{(32-$bits(status)){1'b0}}, status};
                    `FSL_OFF_FADDR: rdata <= {{(32-`FSL_FA_W){1'b0}}, faddr_reg};
                    `FSL_OFF_FDATA: rdata <= {{(32-`FSL_FD_W){1'b0}}, q_a};
                    default: rdata <= '0;
                endcase
            end else begin
                rdata <= '0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst || por);
    // Consecutive test-clock edges with mode-select high, held once the reset count is reached.
    logic [2:0] tms_hi_cnt_reg;
    always_ff @(posedge clock) begin
        if (por) begin
            tms_hi_cnt_reg <= '0;
        end else if (adv) begin
            tms_hi_cnt_reg <= !tms ? 3'h0 : tms_hi_cnt_reg + {2'h0, (tms_hi_cnt_reg != `FSL_TLR_EDGES)};
        end
    end
    property p_secured_fixed;
        !boot_pending_reg && !$past(boot_pending_reg) |-> $stable(secured);
    endproperty
    a_secured_fixed: assert property (p_secured_fixed) else $error("security changed outside boot");
    property p_debug_off;
        secured |=> !core_debug_en;
    endproperty
    a_debug_off: assert property (p_debug_off) else $error("debug enabled while secured");
    property p_idcode;
        adv && tap_reg == FSL_CAP_DR && ir_reg == `FSL_IR_IDCODE |=> dr_reg == ID_CODE;
    endproperty
    a_idcode: assert property (p_idcode) else $error("identification not captured");
    property p_dbg_block;
        adv && tap_reg == FSL_CAP_DR && ir_reg == `FSL_IR_DBG_READ && secured |=> dr_reg == '0;
    endproperty
    a_dbg_block: assert property (p_dbg_block) else $error("flash word leaked while secured");
    property p_erase_end;
        erase_last |=> !erase_busy && done_reg;
    endproperty
    a_erase_end: assert property (p_erase_end) else $error("erase did not finish cleanly");
    property p_div_capture;
        adv && tap_reg == FSL_UPD_DR && is_lockout |=> div_reg == $past(dr_reg[`FSL_DIV_W-1:0]);
    endproperty
    a_div_capture: assert property (p_div_capture) else $error("divider not captured");
    property p_start;
        erase_start |=> erase_busy && erase_addr_reg == `FSL_ADDR_FIRST;
    endproperty
    a_start: assert property (p_start) else $error("erase did not start on idle entry");
    property p_div_frozen;
        erase_busy && $past(erase_busy) |-> $stable(erase_div_reg);
    endproperty
    a_div_frozen: assert property (p_div_frozen) else $error("erase divider changed mid erase");
    property p_abort;
        erase_busy && tap_reg != FSL_RTI |=> !erase_busy && aborted_reg && !done_reg;
    endproperty
    a_abort: assert property (p_abort) else $error("early exit did not abort erase");
    property p_tlr;
        tms_hi_cnt_reg == `FSL_TLR_EDGES |-> tap_reg == FSL_TLR;
    endproperty
    a_tlr: assert property (p_tlr) else $error("TAP not reset after five highs");
endmodule // fsl_lockout

// ### rtl/fsl_params.svh
// Constants of the flash security interlock: offsets, flash locations, codes and widths.
`ifndef FSL_PARAMS_SVH
`define FSL_PARAMS_SVH

// Register offsets on the software port (byte addresses).
`define FSL_OFF_STATUS 8'h00
`define FSL_OFF_FADDR 8'h04
`define FSL_OFF_FDATA 8'h08

// Flash geometry and the security word.
`define FSL_FA_W 15
`define FSL_FD_W 16
`define FSL_FLASH_WORDS 32768
`define FSL_ADDR_FIRST 15'h0000
`define FSL_ADDR_LAST 15'h7FFF
`define FSL_SEC_ADDR 15'h7FF7
`define FSL_SEC_VAL 16'h0002
`define FSL_ERASED 16'hFFFF

// Test access port widths and instruction codes.
`define FSL_IR_W 4
`define FSL_DR_W 32
`define FSL_DIV_W 7
`define FSL_IR_CAPTURE 4'h1
`define FSL_IR_IDCODE 4'h2
`define FSL_IR_LOCKOUT 4'h8
`define FSL_IR_DBG_ADDR 4'hA
`define FSL_IR_DBG_READ 4'hB
`define FSL_IR_BYPASS 4'hF

// Data register lengths per instruction.
`define FSL_LEN_BYPASS 6'h01
`define FSL_LEN_DIV 6'h07
`define FSL_LEN_ADDR 6'h0F
`define FSL_LEN_DATA 6'h10
`define FSL_LEN_ID 6'h20

// Consecutive test-clock edges with mode-select high that force the TAP reset.
`define FSL_TLR_EDGES 3'h5

`endif

// ### rtl/fsl_pkg.sv
// Types shared by the flash security interlock files.
`include "fsl_params.svh"

package fsl_pkg;

    // TAP controller states, Gray coded along the usual walk.
    typedef enum logic [3:0] {
        FSL_TLR = 4'h0,
        FSL_RTI = 4'h1,
        FSL_SEL_DR = 4'h3,
        FSL_CAP_DR = 4'h2,
        FSL_SH_DR = 4'h6,
        FSL_EX1_DR = 4'h7,
        FSL_PAU_DR = 4'h5,
        FSL_EX2_DR = 4'h4,
        FSL_UPD_DR = 4'hC,
        FSL_SEL_IR = 4'hD,
        FSL_CAP_IR = 4'hF,
        FSL_SH_IR = 4'hE,
        FSL_EX1_IR = 4'hA,
        FSL_PAU_IR = 4'hB,
        FSL_EX2_IR = 4'h9,
        FSL_UPD_IR = 4'h8
    } fsl_tap_state_t;

    // One request on the software register port.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } fsl_bus_req_t;

    // Status word seen by software.
    typedef struct packed {
        logic aborted;
        logic done;
        logic busy;
        logic dbg_en;
        logic secured;
    } fsl_status_t;

endpackage : fsl_pkg

// ### tb/fsl_host.sv
// Test host model that drives the test access pins of the interlock.
module fsl_host (
    // System clock that paces the test clock.
    input wire logic clock,
    // Test access pins.
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo
);
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////////////////////////////////////////////
    // The test clock stands still low between frames; mode-select starts high and then keeps its last driven value.
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // One test clock period; tdo is taken just before the rising edge.
    task automatic pulse(input logic m, input logic d, output logic q);
        @(posedge clock);
        tms <= m;
        tdi <= d;
        repeat (3) @(posedge clock);
        q = tdo;
        tck <= 1'b1;
        repeat (3) @(posedge clock);
        tck <= 1'b0;
    endtask

    // Walks from idle through one scan of n bits and back into idle.
    // Idle pulses toggle tdi so a stale data bit is never mistaken for a valid one.
    task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
        logic q;
        dout = '0;
        pulse(1'b1, ~tdi, q);
        if (ir) begin
            pulse(1'b1, ~tdi, q);
        end
        pulse(1'b0, ~tdi, q);
        pulse(1'b0, ~tdi, q);
        for (int i = 0; i < n; i++) begin
            pulse(i == n - 1, din[i], q);
            dout[i] = q;
        end
        pulse(1'b1, ~tdi, q);
        // Returning to idle starts a pending erase; the host then holds still.
        pulse(1'b0, ~tdi, q);
    endtask
endmodule // fsl_host

// ### tb/tb.sv
// Self-checking bench for the flash security interlock.
`include "fsl_params.svh"

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import fsl_pkg::*;

    localparam logic [31:0] ID_VAL = 32'h1234_5675; // Arbitrary identification value.
    logic clock, rst, por, tck, tms, tdi, tdo, tdo_oe, secured, core_debug_en, erase_busy;
    fsl_bus_req_t bus_req;
    logic [31:0] rdata, v;
    int fail_count = 0;
    int num_checks = 0;

    ////////////////////////////////////////////////////////////////////////////////
    // Clock, design and test host.
    initial clock = 1'b0;
    always #5 clock = ~clock;

    fsl_lockout #(.ID_CODE(ID_VAL)) dut (.clock(clock), .rst(rst), .por(por), .tck(tck), .tms(tms),
        .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .bus_req(bus_req), .rdata(rdata), .secured(secured),
        .core_debug_en(core_debug_en), .erase_busy(erase_busy));
    fsl_host host (.clock(clock), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

    ////////////////////////////////////////////////////////////////////////////////
    // Compares one value and counts it.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One write cycle on the register port.
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        bus_req <= {1'b1, 1'b0, a, d};
        @(posedge clock);
        bus_req <= '0;
    endtask

    // One read cycle; the data stand only in the following cycle.
    task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        bus_req <= {1'b0, 1'b1, a, 32'h0};
        @(posedge clock);
        bus_req <= '0;
        #1 d = rdata;
    endtask

    // Programs one flash word; flash_rd reads one back with the required gap.
    task automatic flash_wr(input logic [14:0] a, input logic [15:0] d);
        bus_wr(`FSL_OFF_FADDR, {17'h0, a});
        bus_wr(`FSL_OFF_FDATA, {16'h0, d});
    endtask

    task automatic flash_rd(input logic [14:0] a, output logic [31:0] d);
        bus_wr(`FSL_OFF_FADDR, {17'h0, a});
        bus_rd(`FSL_OFF_FDATA, d);
    endtask

    // Device reset, with power-on reset of the TAP when p is set.
    task automatic do_reset(input logic p);
        logic q;
        @(posedge clock);
        rst <= 1'b1;
        por <= p;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        por <= 1'b0;
        repeat (3) @(posedge clock);
        if (p) begin
            host.pulse(1'b0, 1'b0, q);
        end
    endtask

    // Debug read of one flash word over the test access port.
    task automatic dbg_read(input logic [14:0] a, output logic [31:0] d);
        host.scan(1'b1, 4, {28'h0, `FSL_IR_DBG_ADDR}, v);
        host.scan(1'b0, 15, {17'h0, a}, v);
        host.scan(1'b1, 4, {28'h0, `FSL_IR_DBG_READ}, v);
        host.scan(1'b0, 16, 32'h0, d);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Blank part boots unsecured with debug on; an unmapped read returns zero.
    task automatic t_boot();
        do_reset(1'b1);
        check(secured, 1'b0);
        check(core_debug_en, 1'b1);
        bus_rd(`FSL_OFF_STATUS, v);
        check(v, 32'h2);
        bus_rd(8'h0C, v);
        check(v, 32'h0);
    endtask

    // Writing the security word secures the part across resets; bits never return to one.
    task automatic t_secure();
        flash_wr(`FSL_SEC_ADDR, `FSL_SEC_VAL);
        flash_wr(`FSL_SEC_ADDR, `FSL_ERASED);
        flash_rd(`FSL_SEC_ADDR, v);
        check(v, 32'h2);
        do_reset(1'b0);
        check(secured, 1'b1);
        check(core_debug_en, 1'b0);
        do_reset(1'b1);
        bus_rd(`FSL_OFF_STATUS, v);
        check(v, 32'h1);
    endtask

    // Identification stays readable while secured; debug flash reads are blocked.
    task automatic t_scan();
        host.scan(1'b1, 4, {28'h0, `FSL_IR_IDCODE}, v);
        check(v, {28'h0, `FSL_IR_CAPTURE});
        host.scan(1'b0, 32, 32'h0, v);
        check(v, ID_VAL);
        dbg_read(`FSL_SEC_ADDR, v);
        check(v, 32'h0);
    endtask

    // Leaving idle in mid-erase aborts it and keeps the part secured.
    task automatic t_abort();
        logic q;
        host.scan(1'b1, 4, {28'h0, `FSL_IR_LOCKOUT}, v);
        host.scan(1'b0, 7, 32'h5, v);
        check(erase_busy, 1'b1);
        host.pulse(1'b1, 1'b0, q);
        repeat (2) @(posedge clock);
        check(erase_busy, 1'b0);
        bus_rd(`FSL_OFF_STATUS, v);
        check(v, 32'h11);
    endtask

    // Full recovery erases everything; the part unlocks only after the next device reset.
    task automatic t_recover();
        int n;
        do_reset(1'b1);
        host.scan(1'b1, 4, {28'h0, `FSL_IR_LOCKOUT}, v);
        host.scan(1'b0, 7, 32'h0, v);
        for (n = 0; n < 40000 && erase_busy !== 1'b0; n++) begin
            @(posedge clock);
        end
        check(n < 40000, 1'b1);
        check(secured, 1'b1);
        bus_rd(`FSL_OFF_STATUS, v);
        check(v, 32'h9);
        do_reset(1'b1);
        check(secured, 1'b0);
        flash_rd(`FSL_SEC_ADDR, v);
        check(v, 32'hFFFF);
        flash_rd(`FSL_ADDR_FIRST, v);
        check(v, 32'hFFFF);
    endtask

    // Zeroing the security word unlocks the part only after reset.
    task automatic t_unsec();
        flash_wr(`FSL_SEC_ADDR, `FSL_SEC_VAL);
        do_reset(1'b0);
        check(secured, 1'b1);
        flash_wr(`FSL_SEC_ADDR, 16'h0000);
        check(secured, 1'b1);
        do_reset(1'b1);
        check(secured, 1'b0);
        dbg_read(`FSL_SEC_ADDR, v);
        check(v, 32'h0);
        flash_wr(`FSL_ADDR_FIRST, 16'hA5C3);
        dbg_read(`FSL_ADDR_FIRST, v);
        check(v, 32'hA5C3);
    endtask

    // From Shift-DR, where the output driver is on, five mode-select highs reach reset and identification.
    task automatic t_tlr();
        logic q;
        host.scan(1'b1, 4, {28'h0, `FSL_IR_BYPASS}, v);
        host.pulse(1'b1, 1'b0, q);
        host.pulse(1'b0, 1'b0, q);
        host.pulse(1'b0, 1'b0, q);
        check(tdo_oe, 1'b1);
        repeat (5) host.pulse(1'b1, 1'b0, q);
        check(tdo_oe, 1'b0);
        host.pulse(1'b0, 1'b0, q);
        host.scan(1'b0, 32, 32'h0, v);
        check(v, ID_VAL);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Prints the verdict and ends the run.
    task automatic final_report();
        if (fail_count == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Main sequence.
    initial begin
        rst = 1'b1;
        por = 1'b1;
        bus_req = '0;
        t_boot();
        t_secure();
        t_scan();
        t_abort();
        t_recover();
        t_unsec();
        t_tlr();
        final_report();
    end

    // Watchdog sized well above the full erase plus scans.
    initial begin
        repeat (90000) @(posedge clock);
        fail_count++;
        final_report();
    end
endmodule // tb
